//--- thub_pkg.sv
package thub_pkg;
    // spi instruction bytes
    localparam logic [7:0]  INSTR_READ   = 8'h03;
    localparam logic [7:0]  INSTR_WRITE  = 8'h02;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [2:0]  BIT_FIRST    = 3'h0;
    // memory map, byte addresses
    localparam int          MEM_BYTES    = 1024;
    localparam logic [9:0]  ADDR_CMD     = 10'h000;
    localparam logic [9:0]  RES_BASE     = 10'h010;
    localparam logic [9:0]  RES_END      = 10'h05F;
    localparam logic [9:0]  KEY_BASE     = 10'h0B0;
    localparam logic [9:0]  KEY_END      = 10'h0B3;
    localparam logic [9:0]  EE_RESULT    = 10'h0D0;
    localparam logic [9:0]  GLOBAL_CFG   = 10'h0F0;
    localparam logic [9:0]  MASK_BASE    = 10'h0F4;
    localparam logic [9:0]  MASK_END     = 10'h0F7;
    localparam logic [9:0]  EE_STATUS    = 10'h0F9;
    localparam logic [9:0]  MUX_DELAY    = 10'h0FF;
    localparam logic [9:0]  CHAN_BASE    = 10'h200;
    localparam logic [9:0]  CHAN_END     = 10'h24F;
    localparam logic [9:0]  TABLE_BASE   = 10'h250;
    localparam logic [9:0]  TABLE_END    = 10'h3CF;
    // command status byte
    localparam logic [7:0]  ST_LOCKED    = 8'h00;
    localparam logic [7:0]  ST_NOT_READY = 8'h80;
    localparam logic [7:0]  ST_READY     = 8'h40;
    localparam logic [7:0]  START_MASK   = 8'h80;
    localparam logic [7:0]  DONE_MASK    = 8'h40;
    localparam logic [7:0]  SLEEP_CMD    = 8'h97;
    localparam int          START_BIT    = 7;
    localparam int          CH_MSB       = 4;
    localparam int          CH_LSB       = 0;
    localparam logic [4:0]  CH_FIRST     = 5'h01;
    localparam logic [4:0]  CH_LAST      = 5'h14;
    // channel word fields
    localparam int          TYPE_MSB     = 31;
    localparam int          TYPE_LSB     = 27;
    localparam int          ASSOC_MSB    = 26;
    localparam int          ASSOC_LSB    = 22;
    // timing
    localparam int          CLK_KHZ      = 200000;
    localparam int          WAKE_MS      = 200;
    localparam int          PHASE1_MS    = 100;
    localparam int          WAKE_CYC     = WAKE_MS * CLK_KHZ;
    localparam int          PHASE1_CYC   = PHASE1_MS * CLK_KHZ;
    localparam int          MUX_UNIT_CYC = 100;

    typedef enum logic [2:0] {
        S_STARTUP = 3'h0,
        S_ASSIGN  = 3'h1,
        S_INIT    = 3'h3,
        S_CONV    = 3'h2,
        S_RESULTS = 3'h6,
        S_SLEEP   = 3'h4
    } seq_type;

    typedef enum logic [2:0] {
        P_INSTR  = 3'h0,
        P_ADDR_H = 3'h1,
        P_ADDR_L = 3'h3,
        P_DATA   = 3'h2,
        P_IGNORE = 3'h6
    } phase_type;
endpackage : thub_pkg

//--- temp_hub_spi_memory_sequencer.sv
// Behaviour
// RL1: read is instruction 0x03, address, then device returns data bytes.
// RL2: write is instruction 0x02, address, then data bytes stored from address.
// RL3: per-channel results stored in 80-byte result region 0x010-0x05F.
// RL4: channel words live in 80-byte region 0x200-0x24F, host writable.
// RL5: writing a conversion byte to 0x000 starts the operation.
// RL6: location 0x000 also accepts a sleep command.
// RL7: wake-up of up to 200 ms powers up and clears RAM.
// RL8: after start-up interrupt goes high and status reads 0x40.
// RL9: start-up leads automatically into channel assignment.
// RL10: host writes channel words, or they come from EEPROM; here only host writes load them, there is no EEPROM load.
// RL11: channel word carries sensor type, associated channel, parameters.
// RL12: the command selects the channel to convert.
// RL13: conversion starts automatically after the initiate command.
// RL14: conversion covers selected channel plus named associated channel.
// RL15: during conversion only status reads are allowed.
// RL16: end of conversion raises interrupt, clears start, sets done.
// RL17: after conversion full RAM access returns.
// RL18: one byte location gives EEPROM result code.
// RL19: four-byte mask selects channels for multi-channel runs.
// RL20: one host-writable byte sets mux settling delay.
// RL21: region reserved for custom sensor table data.
// RL22: status unreadable up to 100 ms, then reads not-ready code.
// RL23: reset pin low returns sequencer to start-up.
// RL24: channel words are zero after start-up.
// RL25: reserved addresses ignore writes and read zero.
// RL26: bytes within a transaction use incrementing addresses.
`timescale 1ns/1ps
module temp_hub_spi_memory_sequencer #(
    parameter int WAKE_CYCLES     = thub_pkg::WAKE_CYC,
    parameter int PHASE1_CYCLES   = thub_pkg::PHASE1_CYC,
    parameter int MUX_UNIT_CYCLES = thub_pkg::MUX_UNIT_CYC
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        RESET_N,
    input  wire logic        SCK,
    input  wire logic        CS_N,
    input  wire logic        MOSI,
    output logic             MISO,
    output logic             MISO_OE,
    output logic             INTERRUPT,
    output logic             CONV_REQ,
    output logic [4:0]       CONV_CHANNEL,
    output logic [4:0]       CONV_ASSOC_CHANNEL,
    output logic [31:0]      CONV_CONFIG,
    input  wire logic        CONV_DONE,
    input  wire logic [31:0] CONV_RESULT
);

    // ==========================================================
    // storage and helpers
    // ==========================================================
    logic [7:0]        mem [0:thub_pkg::MEM_BYTES-1];
    thub_pkg::seq_type state_q;
    logic [31:0]       cnt_q;
    logic [7:0]        status_q;

    function automatic logic [9:0] word_addr(input logic [9:0] base,
                                             input logic [4:0] ch);
        word_addr = base + {3'h0, ch - thub_pkg::CH_FIRST, 2'h0};
    endfunction : word_addr

    function automatic logic [31:0] rd_word(input logic [9:0] a);
        rd_word = {mem[a], mem[a + 10'h001], mem[a + 10'h002], mem[a + 10'h003]};
    endfunction : rd_word

    function automatic logic in_range(input logic [9:0] a,
                                      input logic [9:0] lo,
                                      input logic [9:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // everything that is not reserved, status byte excluded
    function automatic logic mapped(input logic [15:0] a);
        logic [9:0] w;
        w = a[9:0];
        mapped = (a[15:10] == 6'h00) && (
            in_range(w, thub_pkg::RES_BASE, thub_pkg::RES_END) ||
            in_range(w, thub_pkg::KEY_BASE, thub_pkg::KEY_END) ||
            w == thub_pkg::EE_RESULT || w == thub_pkg::GLOBAL_CFG ||
            in_range(w, thub_pkg::MASK_BASE, thub_pkg::MASK_END) ||
            w == thub_pkg::EE_STATUS || w == thub_pkg::MUX_DELAY ||
            in_range(w, thub_pkg::CHAN_BASE, thub_pkg::CHAN_END) ||
            in_range(w, thub_pkg::TABLE_BASE, thub_pkg::TABLE_END));
    endfunction : mapped

    // results and eeprom codes are read-only to the host
    function automatic logic writable(input logic [15:0] a);
        writable = mapped(a) &&
            !in_range(a[9:0], thub_pkg::RES_BASE, thub_pkg::RES_END) &&
            a[9:0] != thub_pkg::EE_RESULT &&
            a[9:0] != thub_pkg::EE_STATUS;
    endfunction : writable

    logic restart;
    logic host_ok;
    logic phase1;
    assign restart = RST || !RESET_N; // [RL23]
    assign host_ok = (state_q == thub_pkg::S_ASSIGN) ||
                     (state_q == thub_pkg::S_RESULTS); // [RL17]
    assign phase1  = cnt_q < 32'(PHASE1_CYCLES);

    function automatic logic [7:0] host_read(input logic [15:0] a);
        if (a == {6'h00, thub_pkg::ADDR_CMD}) begin
            if (state_q != thub_pkg::S_STARTUP)
                host_read = status_q;
            else if (phase1)
                host_read = thub_pkg::ST_LOCKED; // [RL22]
            else
                host_read = thub_pkg::ST_NOT_READY; // [RL22]
        end else if (host_ok && mapped(a))
            host_read = mem[a[9:0]]; // [RL18] [RL21]
        else
            host_read = 8'h00; // [RL15] [RL25]
    endfunction : host_read

    // ==========================================================
    // spi slave, mode 0, msb first
    // ==========================================================
    logic                sck_q;
    logic                cs_q;
    logic [6:0]          rx_q;
    logic [2:0]          bit_q;
    thub_pkg::phase_type phase_q;
    logic [7:0]          instr_q;
    logic [15:0]         addr_q;
    logic [7:0]          tx_q;
    logic                load_q;
    logic                sck_rise;
    logic                sck_fall;
    logic                cs_fall;
    logic [7:0]          rx_byte;
    logic                byte_done;
    logic                spi_wr;
    logic                cmd_wr;

    assign sck_rise  = SCK && !sck_q && !CS_N;
    assign sck_fall  = !SCK && sck_q && !CS_N;
    assign cs_fall   = !CS_N && cs_q;
    assign rx_byte   = {rx_q, MOSI};
    assign byte_done = sck_rise && bit_q == thub_pkg::BIT_LAST;
    assign spi_wr    = byte_done && phase_q == thub_pkg::P_DATA &&
                       instr_q == thub_pkg::INSTR_WRITE;
    assign cmd_wr    = spi_wr && host_ok &&
                       addr_q == {6'h00, thub_pkg::ADDR_CMD}; // [RL5]
    assign MISO      = tx_q[7];
    assign MISO_OE   = !CS_N;

    always_ff @(posedge CLK_SYS) begin
        if (restart) begin
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            sck_q <= SCK;
            cs_q  <= CS_N;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (restart || CS_N) begin
            rx_q    <= 7'h00;
            bit_q   <= thub_pkg::BIT_FIRST;
            phase_q <= thub_pkg::P_INSTR;
            instr_q <= 8'h00;
            addr_q  <= 16'h0000;
            tx_q    <= 8'h00;
            load_q  <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (sck_rise) begin
                rx_q  <= rx_byte[6:0];
                bit_q <= bit_q + 3'h1;
                if (bit_q == thub_pkg::BIT_LAST) begin
                    case (phase_q)
                        thub_pkg::P_INSTR: begin
                            instr_q <= rx_byte;
                            if (rx_byte == thub_pkg::INSTR_READ ||
                                rx_byte == thub_pkg::INSTR_WRITE)
                                phase_q <= thub_pkg::P_ADDR_H; // [RL1] [RL2]
                            else
                                phase_q <= thub_pkg::P_IGNORE;
                        end
                        thub_pkg::P_ADDR_H: begin
                            addr_q[15:8] <= rx_byte;
                            phase_q      <= thub_pkg::P_ADDR_L;
                        end
                        thub_pkg::P_ADDR_L: begin
                            addr_q[7:0] <= rx_byte;
                            phase_q     <= thub_pkg::P_DATA;
                            load_q      <= instr_q == thub_pkg::INSTR_READ; // [RL1]
                        end
                        thub_pkg::P_DATA: begin
                            addr_q <= addr_q + 16'h0001; // [RL26]
                            load_q <= instr_q == thub_pkg::INSTR_READ;
                        end
                        default: phase_q <= thub_pkg::P_IGNORE;
                    endcase
                end
            end else if (load_q) begin
                tx_q <= host_read(addr_q); // [RL1] [RL15]
            end else if (sck_fall && bit_q != thub_pkg::BIT_FIRST) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // sequencer
    // ==========================================================
    logic [10:0] clr_q;
    logic        int_q;
    logic [4:0]  ch_q;
    logic        multi_q;
    logic [4:0]  scan_q;
    logic [23:0] settle_q;
    logic        req_q;
    logic [31:0] cfg_q;
    logic [4:0]  sel_ch;
    logic        sel_ok;
    logic [31:0] mask_w;
    logic        res_wr;
    logic        clearing;
    logic [4:0]  cmd_ch;

    always_comb mask_w = rd_word(thub_pkg::MASK_BASE); // [RL19]
    assign sel_ch   = multi_q ? scan_q : ch_q;
    assign sel_ok   = multi_q ? mask_w[scan_q - thub_pkg::CH_FIRST] : 1'b1; // [RL19]
    assign res_wr   = state_q == thub_pkg::S_CONV && req_q && CONV_DONE;
    assign clearing = state_q == thub_pkg::S_STARTUP && !clr_q[10];
    assign cmd_ch   = rx_byte[thub_pkg::CH_MSB:thub_pkg::CH_LSB];

    assign INTERRUPT          = int_q;
    assign CONV_REQ           = req_q;
    assign CONV_CHANNEL       = ch_q;
    assign CONV_CONFIG        = cfg_q;
    assign CONV_ASSOC_CHANNEL = cfg_q[thub_pkg::ASSOC_MSB:thub_pkg::ASSOC_LSB]; // [RL11] [RL14]

    always_ff @(posedge CLK_SYS) begin
        if (restart) begin
            state_q  <= thub_pkg::S_STARTUP; // [RL23]
            cnt_q    <= 32'h0000_0000;
            clr_q    <= 11'h000;
            status_q <= thub_pkg::ST_READY;
            int_q    <= 1'b0;
            ch_q     <= 5'h00;
            multi_q  <= 1'b0;
            scan_q   <= 5'h00;
            settle_q <= 24'h00_0000;
            req_q    <= 1'b0;
            cfg_q    <= 32'h0000_0000;
        end else begin
            case (state_q)
                thub_pkg::S_STARTUP: begin
                    int_q <= 1'b0;
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (clearing)
                        clr_q <= clr_q + 11'h001; // [RL7]
                    if (cnt_q >= 32'(WAKE_CYCLES - 1) && !clearing) begin
                        state_q  <= thub_pkg::S_ASSIGN; // [RL9]
                        status_q <= thub_pkg::ST_READY; // [RL8]
                        int_q    <= 1'b1; // [RL8]
                    end
                end
                thub_pkg::S_ASSIGN, thub_pkg::S_RESULTS: begin
                    if (cmd_wr && rx_byte == thub_pkg::SLEEP_CMD) begin
                        state_q <= thub_pkg::S_SLEEP; // [RL6]
                        int_q   <= 1'b0;
                    end else if (cmd_wr && rx_byte[thub_pkg::START_BIT]) begin
                        status_q <= rx_byte; // [RL5]
                        int_q    <= 1'b0;
                        ch_q     <= cmd_ch; // [RL12]
                        multi_q  <= cmd_ch == 5'h00; // [RL19]
                        scan_q   <= thub_pkg::CH_FIRST;
                        state_q  <= thub_pkg::S_INIT; // [RL13]
                    end
                end
                thub_pkg::S_INIT: begin
                    if (multi_q)
                        scan_q <= scan_q + 5'h01;
                    if (sel_ch < thub_pkg::CH_FIRST || sel_ch > thub_pkg::CH_LAST) begin
                        state_q  <= thub_pkg::S_RESULTS;
                        status_q <= (status_q & ~thub_pkg::START_MASK) | thub_pkg::DONE_MASK;
                        int_q    <= 1'b1;
                    end else if (sel_ok) begin
                        ch_q     <= sel_ch;
                        cfg_q    <= rd_word(word_addr(thub_pkg::CHAN_BASE, sel_ch)); // [RL4] [RL11]
                        settle_q <= 24'(mem[thub_pkg::MUX_DELAY] * MUX_UNIT_CYCLES); // [RL20]
                        state_q  <= thub_pkg::S_CONV; // [RL13]
                    end
                end
                thub_pkg::S_CONV: begin
                    if (settle_q != 24'h00_0000)
                        settle_q <= settle_q - 24'h00_0001; // [RL20]
                    else if (!req_q)
                        req_q <= 1'b1; // [RL14]
                    if (res_wr) begin
                        req_q <= 1'b0;
                        if (multi_q) begin
                            state_q <= thub_pkg::S_INIT;
                        end else begin
                            state_q  <= thub_pkg::S_RESULTS; // [RL17]
                            status_q <= (status_q & ~thub_pkg::START_MASK) |
                                        thub_pkg::DONE_MASK; // [RL16]
                            int_q    <= 1'b1; // [RL16]
                        end
                    end
                end
                thub_pkg::S_SLEEP: begin
                    if (cs_fall) begin
                        state_q <= thub_pkg::S_STARTUP;
                        cnt_q   <= 32'h0000_0000;
                        clr_q   <= 11'h000;
                    end
                end
                default: state_q <= thub_pkg::S_STARTUP;
            endcase
        end
    end

    // ==========================================================
    // memory writes: clear, results, host
    // ==========================================================
    logic [9:0] res_a;
    assign res_a = word_addr(thub_pkg::RES_BASE, ch_q);

    always_ff @(posedge CLK_SYS) begin
        if (clearing) begin
            mem[clr_q[9:0]] <= 8'h00; // [RL7] [RL24]
        end else if (res_wr) begin
            mem[res_a]           <= CONV_RESULT[31:24]; // [RL3]
            mem[res_a + 10'h001] <= CONV_RESULT[23:16];
            mem[res_a + 10'h002] <= CONV_RESULT[15:8];
            mem[res_a + 10'h003] <= CONV_RESULT[7:0];
        end else if (spi_wr && host_ok && writable(addr_q)) begin
            mem[addr_q[9:0]] <= rx_byte; // [RL2] [RL4] [RL10] [RL25]
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    logic [7:0] cmd_view;
    always_comb cmd_view = host_read(16'h0000);

    status_early_a: assert property ( // [RL22]
        (state_q == thub_pkg::S_STARTUP && phase1 && RESET_N) |-> cmd_view == thub_pkg::ST_LOCKED)
        else $error("status readable too early");
    startup_exit_a: assert property ( // [RL7]
        (RESET_N && state_q == thub_pkg::S_STARTUP && cnt_q >= 32'(WAKE_CYCLES - 1) && !clearing)
        |=> state_q == thub_pkg::S_ASSIGN)
        else $error("start-up did not end");
    ready_status_a: assert property ( // [RL8]
        (state_q == thub_pkg::S_STARTUP ##1 state_q == thub_pkg::S_ASSIGN)
        |-> INTERRUPT && cmd_view == thub_pkg::ST_READY)
        else $error("ready status wrong");
    chan_clear_a: assert property ( // [RL24]
        (state_q == thub_pkg::S_STARTUP ##1 state_q == thub_pkg::S_ASSIGN)
        |-> rd_word(thub_pkg::CHAN_BASE) == 32'h0000_0000)
        else $error("channel word not cleared");
    start_conv_a: assert property ( // [RL12]
        (cmd_wr && rx_byte[thub_pkg::START_BIT] && rx_byte != thub_pkg::SLEEP_CMD &&
         cmd_ch >= thub_pkg::CH_FIRST && cmd_ch <= thub_pkg::CH_LAST && RESET_N)
        |=> state_q == thub_pkg::S_INIT ##1
            (state_q == thub_pkg::S_CONV && CONV_CHANNEL == $past(cmd_ch, 2)))
        else $error("conversion not started on channel");
    sleep_cmd_a: assert property ( // [RL6]
        (cmd_wr && rx_byte == thub_pkg::SLEEP_CMD && RESET_N)
        |=> state_q == thub_pkg::S_SLEEP && !INTERRUPT)
        else $error("sleep not entered");
    reset_pin_a: assert property ( // [RL23]
        !RESET_N |=> state_q == thub_pkg::S_STARTUP && !INTERRUPT)
        else $error("reset pin ignored");
    conv_lock_a: assert property ( // [RL15]
        (load_q && state_q == thub_pkg::S_CONV && addr_q != 16'h0000) |=> tx_q == 8'h00)
        else $error("ram readable during conversion");
    conv_end_a: assert property ( // [RL16]
        (res_wr && !multi_q && RESET_N) |=> state_q == thub_pkg::S_RESULTS && INTERRUPT &&
            !status_q[thub_pkg::START_BIT] && (status_q & thub_pkg::DONE_MASK) != 8'h00)
        else $error("end of conversion flags wrong");
    result_store_a: assert property ( // [RL3]
        (res_wr && RESET_N) |=> rd_word($past(res_a)) == $past(CONV_RESULT))
        else $error("result not stored");
    addr_step_a: assert property ( // [RL26]
        (byte_done && phase_q == thub_pkg::P_DATA && !CS_N && RESET_N)
        |=> addr_q == $past(addr_q) + 16'h0001)
        else $error("address did not advance");
    reserved_rd_a: assert property ( // [RL25]
        (load_q && !mapped(addr_q) && addr_q != 16'h0000) |=> tx_q == 8'h00)
        else $error("reserved address not zero");

    multi_run_c: cover property (res_wr && multi_q ##[1:40] state_q == thub_pkg::S_CONV);
    status_poll_c: cover property (state_q == thub_pkg::S_CONV && load_q && addr_q == 16'h0000);
    wake_sleep_c: cover property (state_q == thub_pkg::S_SLEEP ##1 state_q == thub_pkg::S_STARTUP);

endmodule : temp_hub_spi_memory_sequencer

//--- thub_analog_model.sv
`timescale 1ns/1ps
// ==========================================
// analog core stand-in: answers a request
module thub_analog_model #(
    parameter int LAT = 1500
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req,
    input  wire logic [4:0]  ch,
    input  wire logic [4:0]  assoc,
    output logic             done,
    output logic [31:0]      result
);
    int          cnt;
    logic [31:0] val;
    assign val = {8'h5A, 3'h0, assoc, 11'h000, ch};
    always @(posedge clk) begin
        done   <= 1'b0;
        result <= ~val;
        if (rst || !req) begin
            cnt <= 0;
        end else if (cnt == LAT - 1) begin
            cnt    <= 0;
            done   <= 1'b1;
            result <= val;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : thub_analog_model

//--- temp_hub_spi_memory_sequencer_tb_top.sv
`timescale 1ns/1ps
module temp_hub_spi_memory_sequencer_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        reset_n = 1'b1;
    logic        sck = 1'b0;
    logic        cs_n = 1'b1;
    logic        mosi = 1'b0;
    logic        miso;
    logic        irq;
    logic        miso_oe;
    logic [31:0] cfg;
    logic        req;
    logic [4:0]  ch;
    logic [4:0]  assoc;
    logic        done;
    logic [31:0] result;
    int          mismatches = 0;
    int          compares = 0;
    always #2.5 clk_sys = ~clk_sys;
    temp_hub_spi_memory_sequencer #(.WAKE_CYCLES(2000), .PHASE1_CYCLES(500), .MUX_UNIT_CYCLES(1)) dut (
        .CLK_SYS(clk_sys), .RST(rst), .RESET_N(reset_n), .SCK(sck), .CS_N(cs_n),
        .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .INTERRUPT(irq), .CONV_REQ(req),
        .CONV_CHANNEL(ch), .CONV_ASSOC_CHANNEL(assoc), .CONV_CONFIG(cfg),
        .CONV_DONE(done), .CONV_RESULT(result));
    thub_analog_model core (.clk(clk_sys), .rst(rst), .req(req), .ch(ch), .assoc(assoc),
        .done(done), .result(result));
    // ==========================================
    // spi host tasks, mode 0
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic [7:0] o, output logic [7:0] i);
        for (int b = 7; b >= 0; b--) begin
            mosi <= o[b];
            repeat (4) @(posedge clk_sys);
            i[b] = miso;
            sck <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sck <= 1'b0;
        end
    endtask : xfer
    // n bytes, big-endian, in the low 8*n bits
    task automatic spi(input logic [7:0] ins, input logic [9:0] a, input int n,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic [7:0] x;
        rd = 32'h0000_0000;
        cs_n <= 1'b0;
        xfer(ins, x);
        xfer({6'h00, a[9:8]}, x);
        xfer(a[7:0], x);
        for (int k = n - 1; k >= 0; k--) begin
            xfer(wd[8*k +: 8], x);
            rd[8*k +: 8] = x;
        end
        repeat (4) @(posedge clk_sys);
        check({31'h0, miso_oe}, 32'h0000_0001);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : spi
    task automatic wr(input logic [9:0] a, input int n, input logic [31:0] d);
        logic [31:0] r;
        spi(thub_pkg::INSTR_WRITE, a, n, d, r);
    endtask : wr
    task automatic rd_chk(input logic [9:0] a, input int n, input logic [31:0] e);
        logic [31:0] r;
        spi(thub_pkg::INSTR_READ, a, n, 32'h0000_0000, r);
        check(r, e);
    endtask : rd_chk
    task automatic wait_int(input int lim);
        int c;
        c = 0;
        while (irq !== 1'b1 && c < lim) begin
            @(posedge clk_sys);
            c++;
        end
        check({31'h0, irq}, 32'h0000_0001);
    endtask : wait_int
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    // ==========================================
    // tests
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(10'h000, 1, 32'h0000_0000);
        wait_int(4000);
        rd_chk(10'h000, 1, 32'h0000_0040);
        $display("test startup done");
        wr(10'h200, 4, 32'h10C0_0000);
        wr(10'h0FF, 1, 32'h0000_0001);
        wr(10'h001, 1, 32'h0000_00A5);
        rd_chk(10'h200, 4, 32'h10C0_0000);
        rd_chk(10'h0FF, 1, 32'h0000_0001);
        rd_chk(10'h001, 1, 32'h0000_0000);
        $display("test map done");
        wr(10'h000, 1, 32'h0000_0081);
        rd_chk(10'h000, 1, 32'h0000_0081);
        rd_chk(10'h200, 4, 32'h0000_0000);
        check({27'h0, ch}, 32'h0000_0001);
        check({27'h0, assoc}, 32'h0000_0003);
        check(cfg, 32'h10C0_0000);
        wait_int(3000);
        rd_chk(10'h000, 1, 32'h0000_0041);
        rd_chk(10'h010, 4, 32'h5A03_0001);
        rd_chk(10'h200, 4, 32'h10C0_0000);
        $display("test conversion done");
        // channels 1 and 3 through the mask, channel 0 in the command
        wr(10'h0F4, 4, 32'h0000_0005);
        wr(10'h000, 1, 32'h0000_0080);
        wait_int(4000);
        rd_chk(10'h000, 1, 32'h0000_0040);
        rd_chk(10'h014, 4, 32'h0000_0000);
        rd_chk(10'h018, 4, 32'h5A00_0003);
        $display("test multi done");
        wr(10'h000, 1, 32'h0000_0097);
        check({31'h0, irq}, 32'h0000_0000);
        // chip select falling wakes the device into start-up
        rd_chk(10'h000, 1, 32'h0000_0000);
        wait_int(4000);
        rd_chk(10'h200, 4, 32'h0000_0000);
        wr(10'h200, 4, 32'h10C0_0000);
        $display("test sleep done");
        reset_n <= 1'b0;
        @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_chk(10'h000, 1, 32'h0000_0000);
        wait_int(4000);
        rd_chk(10'h200, 4, 32'h0000_0000);
        $display("test restart done");
        end_sim;
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        end_sim;
    end
endmodule : temp_hub_spi_memory_sequencer_tb_top
